// >>> crw_pkg.sv
package crw_pkg;

    // host ring buffer geometry, counted in 32-bit words
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LCTR_W = 16;
    localparam int LEN_W  = 16;

    // record type codes
    localparam logic [7:0] REC_TYPE_RAW_LINK = 8'h18;
    localparam logic [7:0] REC_TYPE_PACKET   = 8'h02;
    localparam logic [7:0] EXT_TYPE_RAW_LINK = 8'h05;

    // header field positions inside the header words
    localparam int TYPE_LSB      = 24;
    localparam int EXT_FLAG_BIT  = 23;
    localparam int MORE_FRAG_BIT = 23;
    localparam int LCTR_LSB      = 0;
    localparam int SEQ_LSB       = 0;
    localparam int LEN_LSB       = 0;

    // header sizes and the largest record ever written
    localparam logic [ADDR_W-1:0] HDR_WORDS_PKT = 16'h0002;
    localparam logic [ADDR_W-1:0] HDR_WORDS_RAW = 16'h0003;
    localparam logic [ADDR_W-1:0] MAX_REC_WORDS = 16'h0200;

    // reset values and the loss counter limit
    localparam logic [ADDR_W-1:0] PTR_RESET  = 16'h0000;
    localparam logic [LCTR_W-1:0] LCTR_RESET = 16'h0000;
    localparam logic [LCTR_W-1:0] LCTR_MAX   = 16'hffff;

    // led blink half period while the host buffer is full
    localparam int CLK_KHZ      = 125000;
    localparam int LED_BLINK_MS = 100;
    localparam int LED_BLINK_CYCLES = LED_BLINK_MS * CLK_KHZ;

    typedef struct packed {
        logic              valid;
        logic              sop;
        logic              eop;
        logic [DATA_W-1:0] data;
    } crw_rx_s;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } crw_wr_s;

    typedef enum {
        ST_IDLE,
        ST_PAYLOAD,
        ST_DROP,
        ST_HDR0,
        ST_HDR1,
        ST_HDR2
    } crw_state_e;

endpackage

// >>> crw_space.sv
`timescale 1ns/10ps
module crw_space
    import crw_pkg::*;
(
    input  wire logic [ADDR_W-1:0] i_wr_ptr,
    input  wire logic [ADDR_W-1:0] i_rd_ptr,
    output logic                   o_full,
    output logic [ADDR_W-1:0]      o_free
);

    // one word is always kept empty so that equal pointers mean empty
    always_comb begin
        o_free = i_rd_ptr - i_wr_ptr - 16'h0001;
        o_full = (o_free < MAX_REC_WORDS);
    end

endmodule

// >>> crw_led.sv
`timescale 1ns/10ps
module crw_led
    import crw_pkg::*;
#(
    parameter int BLINK_CYCLES = LED_BLINK_CYCLES
)
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_full,
    output logic      o_led_level
);

    logic [31:0] count;
    logic [31:0] next_count;
    logic        blink;
    logic        next_blink;

    always_comb begin
        next_count = count;
        next_blink = blink;
        if (!i_full) begin
            next_count = 32'h0000_0000;
            next_blink = 1'b1;
        end else if (count >= 32'(BLINK_CYCLES - 1)) begin
            next_count = 32'h0000_0000;
            next_blink = ~blink;
        end else begin
            next_count = count + 32'h0000_0001;
        end
        // steady on while capturing, flashing while the buffer is full
        o_led_level = i_full ? blink : 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= 32'h0000_0000;
            blink <= 1'b1;
        end else begin
            count <= next_count;
            blink <= next_blink;
        end
    end

endmodule

// >>> crw_writer.sv
// What this block does
// - one capture record per accepted packet
// - drop new packets while buffer full
// - loss counter carried in record header
// - led flashes when host buffer full
// - raw frames wrapped into capture records
// - raw frame records use type 24
// - raw records carry extension header type 5
// - one record per frame at OC-3/OC-12
// - payload starts at first A1 byte
// - single record: more-fragments 0, sequence 0
`timescale 1ns/10ps
module crw_writer
    import crw_pkg::*;
#(
    parameter int LED_BLINK = LED_BLINK_CYCLES
)
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire crw_rx_s           i_rx,
    input  wire logic              i_raw_mode,
    input  wire logic [ADDR_W-1:0] i_rd_ptr,
    output crw_wr_s                o_wr,
    output logic [ADDR_W-1:0]      o_wr_ptr,
    output logic                   o_buffer_full,
    output logic                   o_led
);

    crw_state_e        state;
    crw_state_e        next_state;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] next_wr_ptr;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] next_cnt;
    logic [LCTR_W-1:0] lctr;
    logic [LCTR_W-1:0] next_lctr;
    logic              raw_rec;
    logic              next_raw_rec;
    logic              skip;
    logic              next_skip;
    crw_wr_s           next_wr;
    logic              next_led;
    logic              drop;
    logic              commit;
    logic [ADDR_W-1:0] hdr_len;
    logic [ADDR_W-1:0] max_pay;
    logic [ADDR_W-1:0] free_words;
    logic              space_full;
    logic              led_level;

    // free space only grows as the host moves its read position on
    crw_space u_space (
        .i_wr_ptr (wr_ptr),
        .i_rd_ptr (i_rd_ptr),
        .o_full   (space_full),
        .o_free   (free_words)
    );

    crw_led #(
        .BLINK_CYCLES (LED_BLINK)
    ) u_led (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_full      (space_full),
        .o_led_level (led_level)
    );

    // payload goes first and the header last, so the record length is
    // known; the host only sees a record once the write position moves
    always_comb begin
        next_state   = state;
        next_wr_ptr  = wr_ptr;
        next_cnt     = cnt;
        next_raw_rec = raw_rec;
        next_skip    = skip;
        next_wr      = '0;
        drop         = 1'b0;
        commit       = 1'b0;
        hdr_len      = raw_rec ? HDR_WORDS_RAW : HDR_WORDS_PKT;
        max_pay      = MAX_REC_WORDS - hdr_len;
        unique case (state)
            ST_IDLE: begin
                if (skip) begin
                    if (i_rx.valid && i_rx.eop) begin
                        next_skip = 1'b0;
                    end
                end else if (i_rx.valid && i_rx.sop) begin
                    if (space_full) begin
                        drop = 1'b1;
                        if (!i_rx.eop) begin
                            next_state = ST_DROP;
                        end
                    end else begin
                        // mode is latched per record so a mid-frame
                        // change cannot mix header formats
                        next_raw_rec  = i_raw_mode;
                        next_wr.valid = 1'b1;
                        next_wr.addr  = wr_ptr + (i_raw_mode ?
                                        HDR_WORDS_RAW : HDR_WORDS_PKT);
                        next_wr.data  = i_rx.data;
                        next_cnt      = 16'h0001;
                        next_state    = i_rx.eop ? ST_HDR0 : ST_PAYLOAD;
                    end
                end
            end
            ST_PAYLOAD: begin
                if (i_rx.valid) begin
                    // long packets are cut to fit one record
                    if (cnt < max_pay) begin
                        next_wr.valid = 1'b1;
                        next_wr.addr  = wr_ptr + hdr_len + cnt;
                        next_wr.data  = i_rx.data;
                        next_cnt      = cnt + 16'h0001;
                    end
                    if (i_rx.eop) begin
                        next_state = ST_HDR0;
                    end
                end
            end
            ST_DROP: begin
                if (i_rx.valid && i_rx.eop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HDR0: begin
                next_wr.valid = 1'b1;
                next_wr.addr  = wr_ptr;
                next_wr.data  = {(raw_rec ? REC_TYPE_RAW_LINK :
                                 REC_TYPE_PACKET), raw_rec, 7'h00,
                                 lctr};
                next_state    = ST_HDR1;
            end
            ST_HDR1: begin
                next_wr.valid = 1'b1;
                next_wr.addr  = wr_ptr + 16'h0001;
                next_wr.data  = {16'h0000, cnt[LEN_W-3:0], 2'b00};
                if (raw_rec) begin
                    next_state = ST_HDR2;
                end else begin
                    commit = 1'b1;
                end
            end
            ST_HDR2: begin
                next_wr.valid = 1'b1;
                next_wr.addr  = wr_ptr + 16'h0002;
                next_wr.data  = {EXT_TYPE_RAW_LINK, 1'b0, 7'h00,
                                 16'h0000};
                commit        = 1'b1;
            end
        endcase
        // no buffering: a packet starting while a header is written is lost
        // a dropped packet may also end inside the window; its eop must
        // release the skip here or the next packet would be swallowed
        if ((state == ST_HDR0 || state == ST_HDR1 || state == ST_HDR2) &&
            i_rx.valid) begin
            if (i_rx.sop) begin
                drop = 1'b1;
                if (!i_rx.eop) begin
                    next_skip = 1'b1;
                end
            end else if (skip && i_rx.eop) begin
                next_skip = 1'b0;
            end
        end
        if (commit) begin
            next_wr_ptr = wr_ptr + hdr_len + cnt;
            next_state  = ST_IDLE;
        end
    end

    // counter is cleared as it is written; a drop in that cycle still counts
    always_comb begin
        next_lctr = (state == ST_HDR0) ? LCTR_RESET : lctr;
        if (drop && next_lctr != LCTR_MAX) begin
            next_lctr = next_lctr + 16'h0001;
        end
        next_led = led_level;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state         <= ST_IDLE;
            wr_ptr        <= PTR_RESET;
            cnt           <= PTR_RESET;
            lctr          <= LCTR_RESET;
            raw_rec       <= 1'b0;
            skip          <= 1'b0;
            o_wr          <= '0;
            o_wr_ptr      <= PTR_RESET;
            o_buffer_full <= 1'b0;
            o_led         <= 1'b1;
        end else begin
            state         <= next_state;
            wr_ptr        <= next_wr_ptr;
            cnt           <= next_cnt;
            lctr          <= next_lctr;
            raw_rec       <= next_raw_rec;
            skip          <= next_skip;
            o_wr          <= next_wr;
            o_wr_ptr      <= next_wr_ptr;
            o_buffer_full <= space_full;
            o_led         <= next_led;
        end
    end

    // checks

    a_drop_full: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_IDLE && !skip && i_rx.valid && i_rx.sop && space_full)
        |=> !o_wr.valid && (lctr == $past(lctr) + 16'h0001 ||
                            $past(lctr) == LCTR_MAX))
        else $error("packet written while buffer full");

    a_accept_write: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_IDLE && !skip && i_rx.valid && i_rx.sop && !space_full
         && i_rx.eop)
        |=> o_wr.valid ##1 (state == ST_HDR1)
            ##[1:2] (wr_ptr != $past(wr_ptr)))
        else $error("accepted packet not committed as a record");

    a_first_align: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_IDLE && !skip && i_rx.valid && i_rx.sop && !space_full)
        |=> o_wr.addr == $past(wr_ptr) + (raw_rec ? HDR_WORDS_RAW :
                                          HDR_WORDS_PKT)
            && o_wr.data == $past(i_rx.data))
        else $error("first frame word not at start of payload");

    a_raw_type: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_HDR0 && raw_rec)
        |=> o_wr.data[DATA_W-1:TYPE_LSB] == REC_TYPE_RAW_LINK
            && o_wr.data[EXT_FLAG_BIT])
        else $error("raw record has wrong type code");

    a_ext_header: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_HDR1 && raw_rec)
        |=> ##1 o_wr.valid && o_wr.addr == $past(wr_ptr, 2) + 16'h0002
            && o_wr.data[DATA_W-1:TYPE_LSB] == EXT_TYPE_RAW_LINK)
        else $error("raw record lacks extension header");

    a_single_frag: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_HDR2)
        |=> !o_wr.data[MORE_FRAG_BIT] && o_wr.data[15:SEQ_LSB] == 16'h0000)
        else $error("single record frame marked as fragment");

    a_lctr_report: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_HDR0)
        |=> o_wr.data[LCTR_W-1:LCTR_LSB] == $past(lctr))
        else $error("loss counter missing from header");

    a_lctr_clear: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_HDR0 && !drop) |=> lctr == LCTR_RESET)
        else $error("loss counter not restarted after record");

    a_space_gate: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(state == ST_PAYLOAD) |-> $past(free_words) >= MAX_REC_WORDS)
        else $error("record started without room for it");

    a_led_normal: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !space_full |=> o_led)
        else $error("led not steady during normal capture");

    a_one_record: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        commit |=> state == ST_IDLE && o_wr_ptr == wr_ptr)
        else $error("frame produced more than one record");

    a_skip_release: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        skip && i_rx.valid && i_rx.eop && !i_rx.sop |=> !skip)
        else $error("dropped packet tail swallows next packet");

    a_busy_count: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        state == ST_HDR0 && i_rx.valid && i_rx.sop |=> lctr == 16'h0001)
        else $error("drop beside header write not counted");

    c_busy_drop: cover property (
        @(posedge i_clk) disable iff (!i_reset_n)
        state == ST_HDR1 && skip && i_rx.valid && i_rx.eop);

    c_raw_record: cover property (
        @(posedge i_clk) disable iff (!i_reset_n)
        state == ST_HDR2);

    c_pkt_record: cover property (
        @(posedge i_clk) disable iff (!i_reset_n)
        state == ST_HDR1 && !raw_rec);

    c_drop_full: cover property (
        @(posedge i_clk) disable iff (!i_reset_n)
        drop && space_full);

    c_truncate: cover property (
        @(posedge i_clk) disable iff (!i_reset_n)
        state == ST_PAYLOAD && i_rx.valid && cnt >= max_pay);

endmodule

// >>> crw_host_model.sv
`timescale 1ns/10ps
module crw_host_model
    import crw_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire crw_wr_s           i_wr,
    input  wire logic [ADDR_W-1:0] i_wr_ptr,
    input  wire logic              i_drain,
    output logic [ADDR_W-1:0]      o_rd_ptr,
    output int                     o_n_wr
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_ptr <= PTR_RESET;
            o_n_wr   <= 0;
        end else begin
            if (i_wr.valid) begin
                mem[i_wr.addr] <= i_wr.data;
                o_n_wr         <= o_n_wr + 1;
            end
            // the application takes every committed record at once
            if (i_drain) begin
                o_rd_ptr <= i_wr_ptr;
            end
        end
    end
endmodule

// >>> test_sonet_capture_record_writer.sv
`timescale 1ns/10ps
module test_sonet_capture_record_writer;
    import crw_pkg::*;
    localparam int BLINK = 8;
    logic              i_clk     = 1'b0;
    logic              i_reset_n = 1'b0;
    logic              raw       = 1'b0;
    logic              drain     = 1'b1;
    crw_rx_s           rx        = '0;
    crw_wr_s           wr;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    logic              full;
    logic              led;
    int                n_wr;
    int                n_fail    = 0;
    int                cmp_count = 0;
    logic              rraw [0:6] = '{0, 0, 1, 0, 1, 1, 0};
    int                rn   [0:6] = '{1, 2, 1, 510, 509, 4, 512};
    int                rw   [0:6] = '{1, 2, 1, 510, 509, 4, 510};

    always #4 i_clk = ~i_clk;

    crw_writer #(.LED_BLINK(BLINK)) i_crw_writer (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rx(rx),
        .i_raw_mode(raw), .i_rd_ptr(rd_ptr), .o_wr(wr),
        .o_wr_ptr(wr_ptr), .o_buffer_full(full), .o_led(led)
    );

    crw_host_model i_crw_host_model (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr(wr),
        .i_wr_ptr(wr_ptr), .i_drain(drain), .o_rd_ptr(rd_ptr),
        .o_n_wr(n_wr)
    );

    task automatic final_report;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] m(input logic [ADDR_W-1:0] a);
        return i_crw_host_model.mem[a];
    endfunction

    task automatic word(input logic r, input logic s, input logic e,
                        input int i);
        @(posedge i_clk);
        #1;
        raw = r;
        rx  = {1'b1, s, e, 32'h00a0_0000 + 32'(i)};
    endtask

    // header busy window is at most 4 cycles after eop, 8 is ample
    task automatic send(input logic r, input int n,
                        output logic [ADDR_W-1:0] base);
        base = wr_ptr;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            #1;
            raw = r;
            rx  = {1'b1, i == 0, i == n - 1, 32'h00a0_0000 + 32'(i)};
        end
        @(posedge i_clk);
        #1;
        rx = '0;
        repeat (8) @(posedge i_clk);
    endtask

    task automatic chk_rec(input logic r, input int n,
                           input logic [ADDR_W-1:0] b,
                           input logic [15:0] lc);
        int h;
        int w;
        h = r ? 3 : 2;
        w = (n > 512 - h) ? 512 - h : n;
        chk("hdr0",
            {r ? 8'h18 : 8'h02, r, 7'h00, lc}, m(b));
        chk("len", {16'h0000, 16'(w * 4)}, m(b + 16'h0001));
        if (r) begin
            chk("ext", {8'h05, 1'b0, 23'h000000},
                m(b + 16'h0002));
        end
        chk("first", 32'h00a0_0000, m(16'(b + h)));
        chk("last", 32'h00a0_0000 + 32'(w - 1),
            m(16'(b + h + w - 1)));
        chk("wr_ptr", {16'h0000, 16'(b + h + w)},
            {16'h0000, wr_ptr});
    endtask

    initial begin
        #720000;
        n_fail++;
        final_report();
    end

    initial begin
        logic [ADDR_W-1:0] b;
        logic [ADDR_W-1:0] p;
        int                nw;
        logic              seen_off;
        repeat (8) @(posedge i_clk);
        chk("rst_valid", 32'h0, {31'h0, wr.valid});
        chk("rst_ptr", 32'h0, {16'h0000, wr_ptr});
        chk("rst_full", 32'h0, {31'h0, full});
        chk("rst_led", 32'h1, {31'h0, led});
        #1;
        i_reset_n = 1'b1;
        for (int k = 0; k < 7; k++) begin
            send(rraw[k], rn[k], b);
            chk_rec(rraw[k], rn[k], b, 16'h0000);
            chk("row_len", 32'(rw[k] * 4), m(b + 16'h0001));
            chk("led_on", 32'h1, {31'h0, led});
        end
        // fill the ring for real: records of 512 words until refused
        #1;
        drain = 1'b0;
        for (int k = 0; k < 200 && full !== 1'b1; k++) begin
            send(1'b0, 510, b);
        end
        chk("full", 32'h1, {31'h0, full});
        nw = n_wr;
        p  = wr_ptr;
        repeat (3) send(1'b1, 2, b);
        chk("drop_wr", 32'(nw), 32'(n_wr));
        chk("drop_ptr", {16'h0000, p}, {16'h0000, wr_ptr});
        seen_off = 1'b0;
        repeat (3 * BLINK) begin
            @(posedge i_clk);
            #1;
            if (led === 1'b0) begin
                seen_off = 1'b1;
            end
        end
        chk("led_blink", 32'h1, {31'h0, seen_off});
        #1;
        drain = 1'b1;
        for (int k = 0; k < 20 && full !== 1'b0; k++) begin
            @(posedge i_clk);
        end
        chk("not_full", 32'h0, {31'h0, full});
        send(1'b0, 1, b);
        chk_rec(1'b0, 1, b, 16'h0003);
        send(1'b1, 3, b);
        chk_rec(1'b1, 3, b, 16'h0000);
        // a packet whose sop meets the header write is lost and counted,
        // and its tail must not swallow the packet after it
        b = wr_ptr;
        word(1'b0, 1'b1, 1'b1, 0);
        word(1'b0, 1'b1, 1'b0, 0);
        word(1'b0, 1'b0, 1'b1, 1);
        @(posedge i_clk);
        #1;
        rx = '0;
        repeat (8) @(posedge i_clk);
        chk_rec(1'b0, 1, b, 16'h0000);
        send(1'b0, 1, b);
        chk_rec(1'b0, 1, b, 16'h0001);
        // reset in the middle of a packet leaves the writer idle at zero
        word(1'b0, 1'b1, 1'b0, 0);
        word(1'b0, 1'b0, 1'b0, 1);
        @(posedge i_clk);
        #1;
        i_reset_n = 1'b0;
        rx        = '0;
        @(posedge i_clk);
        chk("rst2_ptr", 32'h0, {16'h0000, wr_ptr});
        chk("rst2_valid", 32'h0, {31'h0, wr.valid});
        #1;
        i_reset_n = 1'b1;
        send(1'b0, 2, b);
        chk("rst2_base", 32'h0, {16'h0000, b});
        chk_rec(1'b0, 2, b, 16'h0000);
        final_report();
    end
endmodule
